/* File: hdl/tw_ctrl.sv */
// Purpose: byte-level two-wire port controller, master and slave
// Assumes: control bits arrive as plain ports with a write strobe
// Notes: scl and sda are open drain, oe high pulls the line low
`timescale 1ns/100ps
module tw_ctrl
   import tw_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // bus pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // control word write
   input wire logic ctl_write,
   input wire logic ctl_flag_clr,
   input wire logic ctl_start,
   input wire logic ctl_stop,
   input wire logic ctl_ack_en,
   input wire logic ctl_enable,
   input wire logic event_irq_enable,
   input wire logic cpu_global_ie,
   // rate and address settings
   input wire logic [7:0] bit_rate_divisor,
   input wire logic [1:0] prescale_sel,
   input wire logic [6:0] own_address_word,
   input wire logic general_call_accept,
   // shift data byte
   input wire logic data_write,
   input wire logic [7:0] data_in,
   output logic [7:0] shift_data_byte,
   // status
   output logic event_flag,
   output logic [7:0] bus_status_word,
   output logic irq
);
   function automatic logic [14:0] presc_val(input logic [1:0] s);
      presc_val = 15'h0001 << {s, 1'b0};
   endfunction

   tw_state_e st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic [14:0] tim_q, tim_d, half_t;
   logic [1:0] ph_q, ph_d;
   logic master_q, master_d, addr_q, addr_d, rd_q, rd_d;
   logic stx_q, stx_d, lost_q, lost_d, slv_q, slv_d, gc_q, gc_d;
   logic ackr_q, ackr_d, ackg_q, ackg_d, busy_q, busy_d;
   logic sda_q, sda_d, scl_q, scl_d, start_q, start_d;
   logic [7:0] shf_q, shf_d;
   logic flag_q, flag_d, ack_en_q, ack_en_d;
   logic [4:0] code_q, code_d, evt_code;
   logic [7:0] stat_q, stat_d;
   logic scl_f, sda_f, scl_p, sda_p;
   logic start_det, stop_det, scl_rise, scl_fall;
   logic evt, clr, go, hdone, tx_bit, own_m, gc_m;
   logic [14:0] lo_len_q, lo_len_d;

   // input spike suppression
   tw_spike #(.N(FILT_CYC)) u_scl (
      .clock(clock), .rst_b(rst_b), .din(scl_i), .dout(scl_f));
   tw_spike #(.N(FILT_CYC)) u_sda (
      .clock(clock), .rst_b(rst_b), .din(sda_i), .dout(sda_f));

   // line history for edge and condition detection
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_p <= scl_f;
         sda_p <= sda_f;
      end
   end

   // detection runs whatever the cpu state, so an address can wake it
   assign start_det = scl_f && scl_p && sda_p && !sda_f;
   assign stop_det = scl_f && scl_p && !sda_p && sda_f;
   // slave timing relies on edges being 8 clocks apart at least
   assign scl_rise = scl_f && !scl_p;
   assign scl_fall = !scl_f && scl_p;

   // master half period from divisor and prescaler
   assign half_t = HALF_BASE + bit_rate_divisor * presc_val(prescale_sel);
   assign hdone = tim_q == half_t - 15'h0001;
   assign clr = ctl_write && ctl_flag_clr;
   assign go = clr && !evt && ctl_enable;
   assign tx_bit = addr_q || !rd_q;
   assign own_m = shf_q[7:1] == own_address_word;
   assign gc_m = general_call_accept && shf_q[7:1] == GC_ADDR;

   // bus sequencer next state
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      tim_d = tim_q;
      ph_d = ph_q;
      master_d = master_q;
      addr_d = addr_q;
      rd_d = rd_q;
      stx_d = stx_q;
      lost_d = lost_q;
      slv_d = slv_q;
      gc_d = gc_q;
      ackr_d = ackr_q;
      ackg_d = ackg_q;
      sda_d = sda_q;
      scl_d = scl_q;
      shf_d = shf_q;
      start_d = start_q;
      busy_d = busy_q;
      evt = 1'b0;
      evt_code = SC_NONE;
      if (start_det) begin
         busy_d = 1'b1;
      end else if (stop_det) begin
         busy_d = 1'b0;
      end
      if (data_write) begin
         shf_d = data_in;
      end
      unique case (st_q)
         ST_IDLE: begin
            scl_d = 1'b1;
            sda_d = 1'b1;
            if ((go && ctl_start) || start_q) begin
               start_d = 1'b1;
            end
            if (((go && ctl_start) || start_q) && !busy_q) begin
               st_d = ST_MSTART;
               ph_d = 2'h1;
               tim_d = 15'h0000;
            end else if (start_det) begin
               st_d = ST_SLV;
               addr_d = 1'b1;
               cnt_d = 4'hF; // wraps to zero on the start's own scl fall
               stx_d = 1'b0;
            end
         end
         ST_MSTART: begin
            tim_d = tim_q + 15'h0001;
            if (ph_q == 2'h0) begin
               scl_d = 1'b0;
               sda_d = 1'b1;
            end else if (ph_q == 2'h1) begin
               scl_d = 1'b1;
               if (!scl_f) begin
                  tim_d = 15'h0000;
               end
            end else begin
               sda_d = 1'b0;
            end
            if (hdone && (ph_q != 2'h1 || scl_f)) begin
               tim_d = 15'h0000;
               ph_d = ph_q + 2'h1;
               if (ph_q == 2'h2) begin
                  scl_d = 1'b0;
                  evt = 1'b1;
                  evt_code = master_q ? SC_RSTART : SC_START;
                  master_d = 1'b1;
                  addr_d = 1'b1;
                  cnt_d = 4'h0;
                  start_d = 1'b0;
                  st_d = ST_HOLD;
               end
            end
         end
         ST_MLO: begin
            scl_d = 1'b0;
            tim_d = tim_q + 15'h0001;
            // data moves one cycle after scl falls, never with it
            if (tim_q == 15'h0000) begin
               sda_d = sda_q;
            end else if (cnt_q <= LAST_BIT) begin
               sda_d = tx_bit ? shf_q[7] : 1'b1;
            end else begin
               sda_d = tx_bit ? 1'b1 : !ack_en_q;
            end
            if (hdone) begin
               tim_d = 15'h0000;
               st_d = ST_MHI;
            end
         end
         ST_MHI: begin
            scl_d = 1'b1;
            if (scl_f) begin
               tim_d = tim_q + 15'h0001;
               if (tim_q == 15'h0000) begin
                  if (cnt_q <= LAST_BIT) begin
                     shf_d = {shf_q[6:0], sda_f};
                  end else begin
                     ackr_d = !sda_f;
                  end
                  if (sda_q && !sda_f && tx_bit && cnt_q <= LAST_BIT) begin
                     master_d = 1'b0;
                     lost_d = 1'b1;
                     sda_d = 1'b1;
                     st_d = ST_SLV;
                  end
               end
            end
            if (hdone && scl_f && st_d == ST_MHI) begin
               tim_d = 15'h0000;
               if (cnt_q == ACK_BIT) begin
                  evt = 1'b1;
                  if (addr_q) begin
                     evt_code = shf_q[0] ? (ackr_q ? SC_AR_ACK : SC_AR_NACK)
                                         : (ackr_q ? SC_AW_ACK : SC_AW_NACK);
                     rd_d = shf_q[0];
                  end else if (rd_q) begin
                     evt_code = ack_en_q ? SC_MR_ACK : SC_MR_NACK;
                  end else begin
                     evt_code = ackr_q ? SC_DT_ACK : SC_DT_NACK;
                  end
                  addr_d = 1'b0;
                  cnt_d = 4'h0;
                  scl_d = 1'b0;
                  st_d = ST_HOLD;
               end else begin
                  cnt_d = cnt_q + 4'h1;
                  st_d = ST_MLO;
               end
            end
         end
         ST_MSTOP: begin
            tim_d = tim_q + 15'h0001;
            if (ph_q == 2'h0) begin
               scl_d = 1'b0;
               sda_d = 1'b0;
            end else if (ph_q == 2'h1) begin
               scl_d = 1'b1;
               if (!scl_f) begin
                  tim_d = 15'h0000;
               end
            end else begin
               sda_d = 1'b1;
            end
            if (hdone && (ph_q != 2'h1 || scl_f)) begin
               tim_d = 15'h0000;
               ph_d = ph_q + 2'h1;
               if (ph_q == 2'h2) begin
                  master_d = 1'b0;
                  st_d = ST_IDLE;
               end
            end
         end
         ST_HOLD: begin
            scl_d = 1'b0;
            sda_d = 1'b1;
            if (go) begin
               lost_d = 1'b0;
               tim_d = 15'h0000;
               ph_d = 2'h0;
               cnt_d = 4'h0;
               if (master_q && ctl_stop) begin
                  start_d = ctl_start;
                  st_d = ST_MSTOP;
               end else if (master_q && ctl_start) begin
                  st_d = ST_MSTART;
               end else if (master_q) begin
                  st_d = ST_MLO;
               end else if (addr_q || slv_q) begin
                  sda_d = stx_q ? shf_q[7] : 1'b1;
                  st_d = ST_SLV;
               end else begin
                  start_d = ctl_start;
                  st_d = ST_IDLE;
               end
            end else if (stop_det && slv_q) begin
               slv_d = 1'b0;
               stx_d = 1'b0;
            end
         end
         ST_SLV: begin
            // slave timing follows the remote scl only
            scl_d = 1'b1;
            if (stx_q && cnt_q <= LAST_BIT) begin
               sda_d = shf_q[3'(LAST_BIT - cnt_q)];
            end else if (cnt_q == ACK_BIT && !stx_q) begin
               sda_d = !ackg_q;
            end else begin
               sda_d = 1'b1;
            end
            if (scl_rise && cnt_q <= LAST_BIT && !stx_q) begin
               shf_d = {shf_q[6:0], sda_f};
            end else if (scl_rise && stx_q) begin
               ackr_d = !sda_f;
            end
            if (scl_fall && cnt_q == LAST_BIT) begin
               cnt_d = ACK_BIT;
               if (addr_q) begin
                  slv_d = ack_en_q && (own_m || gc_m);
                  gc_d = gc_m && !own_m;
                  ackg_d = ack_en_q && (own_m || gc_m);
                  stx_d = shf_q[0];
                  if (!(ack_en_q && (own_m || gc_m)) && !lost_q) begin
                     st_d = ST_IDLE;
                  end
               end else begin
                  ackg_d = !stx_q && ack_en_q;
               end
            end else if (scl_fall && cnt_q == ACK_BIT) begin
               evt = 1'b1;
               if (addr_q) begin
                  evt_code = !slv_q ? SC_ARB : stx_q ? SC_SR_ADDR :
                             gc_q ? SC_GC_ADDR : SC_SW_ADDR;
               end else if (stx_q) begin
                  evt_code = ackr_q ? SC_ST_ACK : SC_ST_NACK;
               end else begin
                  evt_code = ackg_q ? SC_SR_ACK : SC_SR_NACK;
               end
               addr_d = 1'b0;
               cnt_d = 4'h0;
               st_d = ST_HOLD;
            end else if (scl_fall) begin
               cnt_d = cnt_q + 4'h1;
            end
            if ((start_det || stop_det) && slv_q) begin
               evt = 1'b1;
               evt_code = SC_STOP_RX;
               slv_d = 1'b0;
               stx_d = 1'b0;
               addr_d = start_det;
               cnt_d = 4'h0;
               st_d = ST_HOLD;
            end else if (start_det) begin
               addr_d = 1'b1;
               cnt_d = 4'hF; // the restart's scl fall is not a bit
            end else if (stop_det) begin
               st_d = ST_IDLE;
            end
         end
      endcase
      // a foreign start or stop inside our own byte is a bus error
      if ((st_q == ST_MLO || st_q == ST_MHI) && (start_det || stop_det)) begin
         evt = 1'b1;
         evt_code = SC_BUS_ERR;
         master_d = 1'b0;
         addr_d = 1'b0;
         sda_d = 1'b1;
         st_d = ST_HOLD;
      end
      if (!ctl_enable) begin
         evt = 1'b0;
         st_d = ST_IDLE;
         master_d = 1'b0;
         slv_d = 1'b0;
         start_d = 1'b0;
         scl_d = 1'b1;
         sda_d = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         tim_q <= 15'h0000;
         ph_q <= 2'h0;
         master_q <= 1'b0;
         addr_q <= 1'b0;
         rd_q <= 1'b0;
         stx_q <= 1'b0;
         lost_q <= 1'b0;
         slv_q <= 1'b0;
         gc_q <= 1'b0;
         ackr_q <= 1'b0;
         ackg_q <= 1'b0;
         busy_q <= 1'b0;
         sda_q <= 1'b1;
         scl_q <= 1'b1;
         start_q <= 1'b0;
         shf_q <= SHIFT_RST;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         tim_q <= tim_d;
         ph_q <= ph_d;
         master_q <= master_d;
         addr_q <= addr_d;
         rd_q <= rd_d;
         stx_q <= stx_d;
         lost_q <= lost_d;
         slv_q <= slv_d;
         gc_q <= gc_d;
         ackr_q <= ackr_d;
         ackg_q <= ackg_d;
         busy_q <= busy_d;
         sda_q <= sda_d;
         scl_q <= scl_d;
         start_q <= start_d;
         shf_q <= shf_d;
      end
   end

   // flag, code and status word; a new event beats a clear
   always_comb begin
      flag_d = evt ? 1'b1 : (clr ? 1'b0 : flag_q);
      code_d = evt ? evt_code : code_q;
      ack_en_d = ctl_write ? ctl_ack_en : ack_en_q;
      stat_d = {flag_q ? code_q : SC_NONE, 1'b0, prescale_sel};
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         flag_q <= 1'b0;
         code_q <= SC_NONE;
         ack_en_q <= 1'b0;
         stat_q <= {SC_NONE, 3'h0};
      end else begin
         flag_q <= flag_d;
         code_q <= code_d;
         ack_en_q <= ack_en_d;
         stat_q <= stat_d;
      end
   end

   // pins and status outputs
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe = !scl_q || flag_q;
   assign sda_oe = !sda_q;
   assign shift_data_byte = shf_q;
   assign event_flag = flag_q;
   assign bus_status_word = stat_q;
   assign irq = flag_q && event_irq_enable && cpu_global_ie;

   chk_status_follows: assert property (@(posedge clock) disable iff (!rst_b)
      $rose(flag_q) |=> stat_q[7:3] == $past(code_q))
      else $error("status not loaded the cycle after flag");
   chk_status_none: assert property (@(posedge clock) disable iff (!rst_b)
      !flag_q |=> stat_q[7:3] == SC_NONE)
      else $error("status shows a code while flag clear");
   chk_scl_held: assert property (@(posedge clock) disable iff (!rst_b)
      flag_q ##1 flag_q |-> scl_oe && $past(scl_oe))
      else $error("scl released while flag set");
   chk_irq_gate: assert property (@(posedge clock) disable iff (!rst_b)
      irq |-> event_flag && event_irq_enable && cpu_global_ie)
      else $error("irq without all enables");
   chk_hold_idle: assert property (@(posedge clock) disable iff (!rst_b)
      flag_q && ctl_enable && !clr |=> st_q == ST_HOLD || !ctl_enable)
      else $error("bus operation while flag set");
   chk_stop_noflag: assert property (@(posedge clock) disable iff (!rst_b)
      st_q == ST_MSTOP && st_d == ST_IDLE |=> !flag_q)
      else $error("flag set after master stop");
   chk_presc_bits: assert property (@(posedge clock) disable iff (!rst_b)
      ##1 bus_status_word[1:0] == $past(prescale_sel))
      else $error("prescaler bits missing from status word");
   // cycles spent in the master low phase, watched by the rate check
   always_comb begin
      lo_len_d = 15'h0000;
      if (st_q == ST_MLO) begin
         lo_len_d = lo_len_q + 15'h0001;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         lo_len_q <= 15'h0000;
      end else begin
         lo_len_q <= lo_len_d;
      end
   end

   chk_low_len: assert property (@(posedge clock) disable iff (!rst_b)
      st_q == ST_MLO && ctl_enable && !start_det && !stop_det
         |-> (lo_len_q < half_t - 15'h0001) == (st_d == ST_MLO))
      else $error("master low phase length wrong");
   chk_arb_lost: assert property (@(posedge clock) disable iff (!rst_b)
      st_q == ST_MHI && scl_f && tim_q == 15'h0000 && sda_q && !sda_f
         && tx_bit && cnt_q <= LAST_BIT && ctl_enable && !start_det
         && !stop_det |=> !master_q && st_q == ST_SLV && !sda_oe)
      else $error("lost arbitration not handed to slave side");
endmodule

/* File: hdl/tw_pkg.sv */
// Purpose: constants shared by the two-wire port controller
// Assumes: 25 MHz core clock, open-drain scl and sda pads outside
// Notes: status word holds a 5-bit code in [7:3] and prescaler in [1:0]
package tw_pkg;
   // time figures and derived cycle counts
   localparam int CLK_NS = 40;
   localparam int FILT_NS = 50;
   localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
   localparam int SCL_BASE = 16;
   localparam logic [14:0] HALF_BASE = 15'(SCL_BASE / 2);
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [6:0] GC_ADDR = 7'h00;
   localparam logic [7:0] SHIFT_RST = 8'hFF;
   // status codes, placed in bits [7:3] of the status word
   localparam logic [4:0] SC_BUS_ERR = 5'h00;
   localparam logic [4:0] SC_START = 5'h01;
   localparam logic [4:0] SC_RSTART = 5'h02;
   localparam logic [4:0] SC_AW_ACK = 5'h03;
   localparam logic [4:0] SC_AW_NACK = 5'h04;
   localparam logic [4:0] SC_DT_ACK = 5'h05;
   localparam logic [4:0] SC_DT_NACK = 5'h06;
   localparam logic [4:0] SC_ARB = 5'h07;
   localparam logic [4:0] SC_AR_ACK = 5'h08;
   localparam logic [4:0] SC_AR_NACK = 5'h09;
   localparam logic [4:0] SC_MR_ACK = 5'h0A;
   localparam logic [4:0] SC_MR_NACK = 5'h0B;
   localparam logic [4:0] SC_SW_ADDR = 5'h0C;
   localparam logic [4:0] SC_GC_ADDR = 5'h0E;
   localparam logic [4:0] SC_SR_ACK = 5'h10;
   localparam logic [4:0] SC_SR_NACK = 5'h11;
   localparam logic [4:0] SC_STOP_RX = 5'h14;
   localparam logic [4:0] SC_SR_ADDR = 5'h15;
   localparam logic [4:0] SC_ST_ACK = 5'h17;
   localparam logic [4:0] SC_ST_NACK = 5'h18;
   localparam logic [4:0] SC_NONE = 5'h1F;
   // controller states
   typedef enum logic [2:0] {
      ST_IDLE, ST_MSTART, ST_MLO, ST_MHI, ST_MSTOP, ST_HOLD, ST_SLV
   } tw_state_e;
endpackage

/* File: hdl/tw_spike.sv */
// Purpose: spike suppression on one bus input
// Assumes: input already synchronous to clock
// Notes: output follows input only after it stands for N cycles
`timescale 1ns/100ps
module tw_spike
   import tw_pkg::*;
#(
   parameter int N = FILT_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_b,
   // line
   input wire logic din,
   output logic dout
);
   logic [2:0] cnt_q, cnt_d;
   logic out_q, out_d;

   // count cycles the input differs from the output
   always_comb begin
      cnt_d = 3'h0;
      out_d = out_q;
      if (din != out_q) begin
         cnt_d = cnt_q + 3'h1;
         if (cnt_q == 3'(N - 1)) begin
            out_d = din;
            cnt_d = 3'h0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 3'h0;
         out_q <= 1'b1;
      end else begin
         cnt_q <= cnt_d;
         out_q <= out_d;
      end
   end

   assign dout = out_q;

   chk_spike_held: assert property (@(posedge clock) disable iff (!rst_b)
      $changed(out_q) |-> $past(din) == out_q && $past(din, 2) == out_q)
      else $error("filtered line moved on a short spike");
endmodule

/* File: test/tw_slave_model.sv */
// Purpose: behavioural slave standing at the far end of the bus
// Assumes: bench resolves the open-drain lines with pull-ups
// Notes: acks its own address; data ack is chosen by nack_data
`timescale 1ns/100ps
module tw_slave_model #(
   parameter logic [6:0] ADDR = 7'h2A
) (
   // bus lines
   input wire logic scl,
   input wire logic sda,
   // behaviour
   input wire logic nack_data,
   output logic sda_pull
);
   logic [7:0] sh = 8'h00;
   int cnt = 0;
   logic act = 1'b0;
   logic adr = 1'b0;
   initial sda_pull = 1'b0;
   // start or restart: sda falls while scl high
   always @(negedge sda) begin
      if (scl) begin
         act = 1'b1;
         adr = 1'b1;
         cnt = 0;
      end
   end
   // stop: sda rises while scl high
   always @(posedge sda) begin
      if (scl) act = 1'b0;
   end
   // shift in msb first on the rising scl of each of the eight data bits
   always @(posedge scl) begin
      if (act && cnt < 8) begin
         sh = {sh[6:0], sda};
         cnt = cnt + 1;
      end
   end
   // ack slot driven in the low phase before the ninth clock
   always @(negedge scl) begin
      if (act && cnt == 8) begin
         sda_pull = adr ? (sh[7:1] == ADDR) : !nack_data;
         cnt = 9;
      end else if (act && cnt == 9) begin
         sda_pull = 1'b0;
         cnt = 0;
         adr = 1'b0;
      end
   end
endmodule

/* File: test/testbench.sv */
// Purpose: self-checking bench for the two-wire port controller
// Assumes: master writes to one slave model, lines pulled up
// Notes: rate, prescale and data drawn from a fixed-seed xorshift
`timescale 1ns/100ps
module testbench;
   import tw_pkg::*;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic wr = 0, clr = 0, sta = 0, sto = 0, ie = 0, gie = 0, dw = 0;
   logic nack_data = 0, ack = 0, m_scl = 0, m_sda = 0, a;
   logic [7:0] div = 0, din = 0, d;
   logic [1:0] sel = 0;
   logic [31:0] seed = 64850;
   wire scl_oe, sda_oe, pull, flag, irq;
   wire [7:0] sbyte, status;
   wire scl = ~(scl_oe | m_scl);
   wire sda = ~(sda_oe | pull | m_sda);
   int fails = 0, num_checks = 0, n, t, k;
   always #20 clock = ~clock;
   // device under test and far-end slave
   tw_ctrl dut (.clock(clock), .rst_b(rst_b), .scl_i(scl), .scl_o(),
      .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
      .ctl_write(wr), .ctl_flag_clr(clr), .ctl_start(sta),
      .ctl_stop(sto), .ctl_ack_en(ack), .ctl_enable(1'b1),
      .event_irq_enable(ie), .cpu_global_ie(gie),
      .bit_rate_divisor(div), .prescale_sel(sel),
      .own_address_word(7'h10), .general_call_accept(1'b0),
      .data_write(dw), .data_in(din), .shift_data_byte(sbyte),
      .event_flag(flag), .bus_status_word(status), .irq(irq));
   tw_slave_model slv (.scl(scl), .sda(sda), .nack_data(nack_data),
      .sda_pull(pull));
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function logic [7:0] st(input logic [4:0] c);
      return {c, 1'b0, sel};
   endfunction
   task chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task tally_and_finish;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task tick;
      @(posedge clock);
      #1;
   endtask
   // one control word write, pulse lasts a single cycle
   task ctl(input logic s, input logic p, input logic c);
      {wr, sta, sto, clr} = {1'b1, s, p, c};
      tick;
      {wr, sta, sto, clr} = 4'h0;
   endtask
   task wait_flag;
      for (int i = 0; i < 20000 && flag !== 1'b1; i++) tick;
      if (flag !== 1'b1) begin
         fails++;
         tally_and_finish;
      end
      tick;
   endtask
   // length of one full scl low phase once the stretch is released
   task low_width(output int w);
      int i;
      w = 0;
      for (i = 0; i < 5000 && scl !== 1'b1; i++) tick;
      for (i = 0; i < 5000 && scl !== 1'b0; i++) tick;
      for (i = 0; i < 5000 && scl === 1'b0; i++) begin
         w++;
         tick;
      end
   endtask
   task load(input logic [7:0] v);
      din = v;
      dw = 1'b1;
      tick;
      dw = 1'b0;
   endtask
   // one bit as a remote master, 17 clocks a period; s is sda seen
   // in the middle of the high phase
   task mbit(input logic b, output logic s);
      m_sda = !b;
      repeat (8) tick;
      m_scl = 1'b0;
      repeat (4) tick;
      s = sda;
      repeat (4) tick;
      m_scl = 1'b1;
      tick;
   endtask
   // main sequence: three master writes, the last to a missing slave
   initial begin
      repeat (6) @(posedge clock);
      #1 rst_b = 1'b1;
      tick;
      chk(status, st(SC_NONE));
      chk(sbyte, 8'hFF);
      for (t = 0; t < 3; t++) begin
         div = 8'(xs() & 32'h3);
         sel = 2'(xs() & 32'h1);
         d = 8'(xs());
         nack_data = (t == 1);
         ctl(1'b1, 1'b0, 1'b1);
         wait_flag;
         chk(status, st(SC_START));
         repeat (20) tick;
         chk({7'h00, scl}, 8'h00);
         for (k = 0; k < 4; k++) begin
            {ie, gie} = 2'(k);
            #1 chk({7'h00, irq}, {7'h00, k == 3});
         end
         {ie, gie} = 2'b00;
         ctl(1'b0, 1'b0, 1'b0);
         repeat (4) tick;
         chk({7'h00, flag}, 8'h01);
         load({(t == 2) ? 7'h55 : 7'h2A, 1'b0});
         ctl(1'b0, 1'b0, 1'b1);
         tick;
         chk(status, st(SC_NONE));
         low_width(n);
         chk(8'(n), 8'(8 + div * (1 << (2 * sel))));
         wait_flag;
         chk(status, st((t == 2) ? SC_AW_NACK : SC_AW_ACK));
         if (t != 2) begin
            load(d);
            ctl(1'b0, 1'b0, 1'b1);
            wait_flag;
            chk(status, st((t == 1) ? SC_DT_NACK : SC_DT_ACK));
            chk(sbyte, d);
         end
         ctl(1'b0, 1'b1, 1'b1);
         repeat (400) tick;
         chk({6'h00, flag, scl & sda}, 8'h01);
      end
      // remote master addresses us; slave side ignores the rate settings
      {div, sel} = {8'hFF, 2'h3};
      ack = 1'b1;
      ctl(1'b0, 1'b0, 1'b0);
      d = {7'h10, 1'b0};
      m_sda = 1'b1;
      repeat (8) tick;
      m_scl = 1'b1;
      tick;
      for (k = 7; k >= 0; k--) mbit(d[k], a);
      mbit(1'b1, a);
      chk({7'h00, a}, 8'h00);
      wait_flag;
      chk(status, st(SC_SW_ADDR));
      // stop from the remote master while still addressed
      m_sda = 1'b1;
      ctl(1'b0, 1'b0, 1'b1);
      repeat (8) tick;
      m_scl = 1'b0;
      repeat (8) tick;
      m_sda = 1'b0;
      wait_flag;
      chk(status, st(SC_STOP_RX));
      ctl(1'b0, 1'b0, 1'b1);
      repeat (4) tick;
      chk({6'h00, flag, scl & sda}, 8'h01);
      tally_and_finish;
   end
endmodule
